/* File: hw/iwpc_ctrl.sv */
// interrupt option, source routing and low-power sequencing block
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
module iwpc_ctrl
   import iwpc_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // axi4-lite write
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // interrupt sources (pins, other domains)
   input wire logic nmiPin,
   input wire logic source1Pin,
   input wire logic source2Pin,
   input wire logic timerOverflowFlag,
   input wire logic timerIrqEnable,
   input wire logic converterEocFlag,
   input wire logic converterIrqEnable,
   input wire logic watchdogActive,
   // core handshake
   input wire logic instrEnd,
   input wire logic waitExec,
   input wire logic stopExec,
   input wire logic handlerStart,
   input wire logic handlerDone,
   // core control
   output logic irqTake,
   output logic [2:0] irqVector,
   output logic coreHalt,
   output logic oscStop,
   output logic resumeNext,
   output logic nmiMode,
   output logic intMode
);
   import iwpc_pkg::*;

   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef struct packed {
      logic [7:0] option;
      logic [1:0] nmiSync;
      logic [1:0] s1Sync;
      logic [1:0] s2Sync;
      logic [1:0] tmSync;
      logic [1:0] adSync;
      logic nmiPrev;
      logic s2Prev;
      logic s1Prev;
      logic nmiLatch;
      logic s1Latch;
      logic s2Latch;
      iwpc_mode_t mode;
      logic [12:0] stabCnt;
      logic nmiMode;
      logic intMode;
      logic resume;
      logic take;
      logic [2:0] vector;
      logic awHeld;
      logic [11:0] awAddr;
      logic wHeld;
      logic [31:0] wData;
      logic [3:0] wStrb;
      logic bValid;
      logic [1:0] bResp;
      logic rValid;
      logic [31:0] rData;
      logic [1:0] rResp;
   } iwpc_state_t;

   iwpc_state_t state_r;
   iwpc_state_t state_nxt;

   logic levelSel;
   logic polSel;
   logic gen;
   logic s1Req;
   logic s2Edge;
   logic tmReq;
   logic adReq;
   logic anyMaskable;
   logic wakeReq;
   logic pendEnabled;

   // ----------------------------------------
   // request logic
   // ----------------------------------------
   always_comb
   begin
      levelSel = state_r.option[IWPC_LEVEL_BIT];
      polSel = state_r.option[IWPC_POL_BIT];
      gen = state_r.option[IWPC_GEN_BIT];
      // source two: one picks rising, zero falling
      s2Edge = polSel ? (state_r.s2Sync[1] & ~state_r.s2Prev)
                      : (~state_r.s2Sync[1] & state_r.s2Prev);
      // source one level mode is active low, no storage
      s1Req = levelSel ? ~state_r.s1Sync[1] : state_r.s1Latch;
      tmReq = state_r.tmSync[1] & timerIrqEnable;
      adReq = state_r.adSync[1] & converterIrqEnable;
      anyMaskable = s1Req | state_r.s2Latch | tmReq | adReq;
      pendEnabled = state_r.nmiLatch | (gen & anyMaskable);
      // nmi stays serviceable but is not a wake cause with gen low
      wakeReq = gen & (state_r.nmiLatch | anyMaskable);
   end

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb
   begin
      logic wrGo;
      logic rdGo;
      wrGo = 1'b0;
      rdGo = 1'b0;
      state_nxt = state_r;

      // two-flop synchronisers; first stage feeds only the second
      state_nxt.nmiSync = {state_r.nmiSync[0], nmiPin};
      state_nxt.s1Sync = {state_r.s1Sync[0], source1Pin};
      state_nxt.s2Sync = {state_r.s2Sync[0], source2Pin};
      state_nxt.tmSync = {state_r.tmSync[0], timerOverflowFlag};
      state_nxt.adSync = {state_r.adSync[0], converterEocFlag};
      state_nxt.nmiPrev = state_r.nmiSync[1];
      state_nxt.s1Prev = state_r.s1Sync[1];
      state_nxt.s2Prev = state_r.s2Sync[1];
      state_nxt.take = 1'b0;
      state_nxt.resume = 1'b0;

      // ----------------------------------------
      // take and clear: latches clear on the take cycle, nmi again at handler start; new edges win over the clear
      // ----------------------------------------
      if (state_r.take)
      begin
         unique case (state_r.vector)
            IWPC_VEC_NMI: state_nxt.nmiLatch = 1'b0;
            IWPC_VEC_PORTA: state_nxt.s1Latch = 1'b0;
            IWPC_VEC_PORTB: state_nxt.s2Latch = 1'b0;
            default: ;
         endcase
      end
      if (handlerStart)
      begin
         if (state_r.vector == IWPC_VEC_NMI)
            state_nxt.nmiLatch = 1'b0;
      end
      // ----------------------------------------
      // edge latches
      // ----------------------------------------
      // nmi pin is active low, falling edge
      if (~state_r.nmiSync[1] & state_r.nmiPrev)
         state_nxt.nmiLatch = 1'b1;
      if (~levelSel & ~state_r.s1Sync[1] & state_r.s1Prev)
         state_nxt.s1Latch = 1'b1;
      if (s2Edge)
         state_nxt.s2Latch = 1'b1;
      if (handlerDone)
      begin
         if (state_r.nmiMode)
            state_nxt.nmiMode = 1'b0;
         else
            state_nxt.intMode = 1'b0;
      end

      // ----------------------------------------
      // mode sequencing
      // ----------------------------------------
      unique case (state_r.mode)
         IWPC_RUN:
         begin
            if (instrEnd)
            begin
               // sampled once per instruction boundary
               if (state_r.nmiLatch & ~state_r.nmiMode)
               begin
                  state_nxt.take = 1'b1;
                  state_nxt.vector = IWPC_VEC_NMI;
                  state_nxt.nmiMode = 1'b1;
               end
               else if (gen & anyMaskable & ~state_r.intMode & ~state_r.nmiMode)
               begin
                  state_nxt.take = 1'b1;
                  state_nxt.intMode = 1'b1;
                  if (s1Req)
                     state_nxt.vector = IWPC_VEC_PORTA;
                  else if (state_r.s2Latch)
                     state_nxt.vector = IWPC_VEC_PORTB;
                  else if (tmReq)
                     state_nxt.vector = IWPC_VEC_TIMER;
                  else
                     state_nxt.vector = IWPC_VEC_ADC;
               end
               else if ((waitExec | stopExec) & ~pendEnabled)
               begin
                  // watchdog keeps the clock alive, so stop degrades to wait
                  state_nxt.mode = (stopExec & ~watchdogActive) ? IWPC_STOP : IWPC_WAIT;
               end
            end
         end
         IWPC_WAIT:
         begin
            if (wakeReq)
            begin
               state_nxt.mode = IWPC_RUN;
               state_nxt.resume = state_r.nmiMode | state_r.intMode;
            end
         end
         IWPC_STOP:
         begin
            if (wakeReq)
            begin
               state_nxt.mode = IWPC_STAB;
               state_nxt.stabCnt = 13'(IWPC_STAB_CYC - 1);
            end
         end
         IWPC_STAB:
         begin
            if (state_r.stabCnt == 13'h0)
            begin
               state_nxt.mode = IWPC_RUN;
               state_nxt.resume = state_r.nmiMode | state_r.intMode;
            end
            else
               state_nxt.stabCnt = state_r.stabCnt - 13'h1;
         end
      endcase

      // ----------------------------------------
      // axi4-lite write: address and data in either order
      // ----------------------------------------
      if (s_axi_awvalid & ~state_r.awHeld)
      begin
         state_nxt.awHeld = 1'b1;
         state_nxt.awAddr = s_axi_awaddr;
      end
      if (s_axi_wvalid & ~state_r.wHeld)
      begin
         state_nxt.wHeld = 1'b1;
         state_nxt.wData = s_axi_wdata;
         state_nxt.wStrb = s_axi_wstrb;
      end
      wrGo = state_r.awHeld & state_r.wHeld & ~state_r.bValid;
      if (wrGo)
      begin
         state_nxt.awHeld = 1'b0;
         state_nxt.wHeld = 1'b0;
         state_nxt.bValid = 1'b1;
         state_nxt.bResp = IWPC_RESP_OKAY;
         if (state_r.awAddr[11:2] == IWPC_OPT_ADDR[11:2])
         begin
            // writes without lane 0 refused: the byte is written whole, only bits 6:4 kept
            if (state_r.wStrb[0])
               state_nxt.option = {1'b0, state_r.wData[6:4], 4'h0};
            else
               state_nxt.bResp = IWPC_RESP_SLVERR;
         end
         else
            state_nxt.bResp = IWPC_RESP_SLVERR;
      end
      if (state_r.bValid & s_axi_bready)
         state_nxt.bValid = 1'b0;

      // ----------------------------------------
      // axi4-lite read
      // ----------------------------------------
      rdGo = s_axi_arvalid & ~state_r.rValid;
      if (rdGo)
      begin
         state_nxt.rValid = 1'b1;
         state_nxt.rResp = IWPC_RESP_OKAY;
         unique case (s_axi_araddr[11:2])
            IWPC_OPT_ADDR[11:2]: state_nxt.rData = 32'h0;
            IWPC_STAT_ADDR[11:2]: state_nxt.rData = {24'h0, state_r.mode, 2'h0,
                                                     state_r.intMode, state_r.nmiMode};
            IWPC_SRC_ADDR[11:2]: state_nxt.rData = {27'h0, adReq, tmReq, state_r.s2Latch,
                                                    s1Req, state_r.nmiLatch};
            default:
            begin
               state_nxt.rData = 32'h0;
               state_nxt.rResp = IWPC_RESP_SLVERR;
            end
         endcase
      end
      if (state_r.rValid & s_axi_rready)
         state_nxt.rValid = 1'b0;
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state_r <= '0;
         state_r.option <= IWPC_OPT_RESET;
         state_r.mode <= IWPC_RUN;
         state_r.nmiSync <= 2'h3;
         state_r.s1Sync <= 2'h3;
         state_r.nmiPrev <= 1'b1;
         state_r.s1Prev <= 1'b1;
         // source two idles high; avoids a false edge after reset
         state_r.s2Sync <= 2'h3;
         state_r.s2Prev <= 1'b1;
      end
      else
         state_r <= state_nxt;
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign s_axi_awready = ~state_r.awHeld;
   assign s_axi_wready = ~state_r.wHeld;
   assign s_axi_bvalid = state_r.bValid;
   assign s_axi_bresp = state_r.bResp;
   assign s_axi_arready = ~state_r.rValid;
   assign s_axi_rvalid = state_r.rValid;
   assign s_axi_rdata = state_r.rData;
   assign s_axi_rresp = state_r.rResp;

   // ----------------------------------------
   // core outputs
   // ----------------------------------------
   assign irqTake = state_r.take;
   assign irqVector = state_r.vector;
   assign coreHalt = state_r.mode != IWPC_RUN;
   assign oscStop = state_r.mode == IWPC_STOP;
   assign resumeNext = state_r.resume;
   assign nmiMode = state_r.nmiMode;
   assign intMode = state_r.intMode;
endmodule // iwpc_ctrl

/* File: hw/iwpc_pkg.sv */
// package: register map, field positions and timing constants for interrupt wake and power control
package iwpc_pkg;
   // ----------------------------------------
   // register map
   // ----------------------------------------
   localparam logic [11:0] IWPC_OPT_ADDR = 12'h0C8;
   localparam logic [11:0] IWPC_STAT_ADDR = 12'h0CC;
   localparam logic [11:0] IWPC_SRC_ADDR = 12'h0D0;
   localparam logic [7:0] IWPC_OPT_RESET = 8'h00;
   localparam int IWPC_LEVEL_BIT = 6;
   localparam int IWPC_POL_BIT = 5;
   localparam int IWPC_GEN_BIT = 4;
   localparam logic [1:0] IWPC_RESP_OKAY = 2'h0;
   localparam logic [1:0] IWPC_RESP_SLVERR = 2'h2;
   // ----------------------------------------
   // vectors and timing
   // ----------------------------------------
   localparam logic [2:0] IWPC_VEC_NMI = 3'h0;
   localparam logic [2:0] IWPC_VEC_PORTA = 3'h1;
   localparam logic [2:0] IWPC_VEC_PORTB = 3'h2;
   localparam logic [2:0] IWPC_VEC_TIMER = 3'h3;
   localparam logic [2:0] IWPC_VEC_ADC = 3'h4;
   localparam int IWPC_STAB_NS = 20000;
   localparam int IWPC_CLK_NS = 5;
   localparam int IWPC_STAB_CYC = IWPC_STAB_NS / IWPC_CLK_NS;
   typedef enum logic [3:0] {
      IWPC_RUN = 4'h1,
      IWPC_WAIT = 4'h2,
      IWPC_STOP = 4'h4,
      IWPC_STAB = 4'h8
   } iwpc_mode_t;
endpackage

/* File: dv/iwpc_ctrl_monitor.sv */
// checker: port assertions for the interrupt and power control block
module iwpc_ctrl_monitor (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // bus
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   // core side
   input wire logic instrEnd,
   input wire logic waitExec,
   input wire logic stopExec,
   input wire logic watchdogActive,
   input wire logic irqTake,
   input wire logic [2:0] irqVector,
   input wire logic coreHalt,
   input wire logic oscStop
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   // ----------------------------------------
   // properties
   // ----------------------------------------
   property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
   a_b_hold: assert property (p_b_hold) else $error("write response dropped");
   property p_r_ans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
   a_r_ans: assert property (p_r_ans) else $error("read not answered");
   property p_take_one; irqTake |=> !irqTake; endproperty
   a_take_one: assert property (p_take_one) else $error("take longer than one cycle");
   property p_vec; irqTake |-> irqVector <= 3'h4; endproperty
   a_vec: assert property (p_vec) else $error("vector out of range");
   property p_osc; oscStop |-> coreHalt; endproperty
   a_osc: assert property (p_osc) else $error("oscillator off while running");
   property p_halt_cause; $rose(coreHalt) |-> $past(instrEnd) && ($past(waitExec) || $past(stopExec)); endproperty
   a_halt_cause: assert property (p_halt_cause) else $error("halt without sleep instruction");
   property p_wd; $rose(oscStop) |-> !$past(watchdogActive) && $past(stopExec); endproperty
   a_wd: assert property (p_wd) else $error("stop honoured with watchdog");
   property p_stab; $fell(oscStop) |-> coreHalt [*8]; endproperty
   a_stab: assert property (p_stab) else $error("no stabilisation delay");
   cover property (irqTake && irqVector == 3'h3);
   cover property ($fell(oscStop));
   cover property ($fell(coreHalt));
endmodule // iwpc_ctrl_monitor

bind iwpc_ctrl iwpc_ctrl_monitor u_mon (.*);

/* File: dv/iwpc_core_model.sv */
// partner: behavioural core issuing instruction ends and handler events
module iwpc_core_model (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // from block and bench
   input wire logic coreHalt,
   input wire logic irqTake,
   input wire logic cmdWait,
   input wire logic cmdStop,
   // to block
   output logic instrEnd,
   output logic waitExec,
   output logic stopExec,
   output logic handlerStart,
   output logic handlerDone
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [2:0] cnt;
   logic [3:0] hcnt;
   assign waitExec = cmdWait;
   assign stopExec = cmdStop;
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         cnt <= 3'h0;
         hcnt <= 4'h0;
         instrEnd <= 1'b0;
         handlerStart <= 1'b0;
         handlerDone <= 1'b0;
      end
      else
      begin
         cnt <= cnt + 3'h1;
         instrEnd <= !coreHalt && cnt == 3'h3;
         handlerStart <= irqTake;
         hcnt <= irqTake ? 4'hA : ((hcnt != 4'h0 && !coreHalt) ? hcnt - 4'h1 : hcnt);
         handlerDone <= hcnt == 4'h1;
      end
   end
endmodule // iwpc_core_model

/* File: dv/iwpc_ctrl_test.sv */
// testbench: register, routing and low-power scenarios
module iwpc_ctrl_test;
   import iwpc_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;
   logic sys_clk = 1'b0, reset_n = 1'b0;
   logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'h0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic nmiPin = 1'b1, source1Pin = 1'b1, source2Pin = 1'b1, watchdogActive = 1'b0;
   logic timerOverflowFlag = 1'b0, timerIrqEnable = 1'b0, converterEocFlag = 1'b0, converterIrqEnable = 1'b0;
   logic cmdWait = 1'b0, cmdStop = 1'b0;
   logic instrEnd, waitExec, stopExec, handlerStart, handlerDone;
   logic irqTake, coreHalt, oscStop, resumeNext, nmiMode, intMode;
   logic [2:0] irqVector;
   int num_errors = 0, checked = 0;
   logic [1:0] rsp;
   logic [31:0] dat;
   logic seen;
   logic [2:0] vec;
   iwpc_ctrl DUT (.*);
   iwpc_core_model u_core (.*);
   always #2.5 sys_clk = ~sys_clk;
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e)
      begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic report_and_stop();
      if (num_errors == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
      logic aw, w;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(negedge sys_clk);
         aw = s_axi_awvalid & s_axi_awready;
         w = s_axi_wvalid & s_axi_wready;
         @(posedge sys_clk);
         if (aw) s_axi_awvalid <= 1'b0;
         if (w) s_axi_wvalid <= 1'b0;
      end while (!(aw | !s_axi_awvalid) || !(w | !s_axi_wvalid));
      do @(negedge sys_clk); while (!s_axi_bvalid);
      rsp = s_axi_bresp;
      @(posedge sys_clk);
      s_axi_bready <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic axi_read(input logic [11:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(negedge sys_clk); while (!s_axi_arready);
      @(posedge sys_clk);
      s_axi_arvalid <= 1'b0;
      do @(negedge sys_clk); while (!s_axi_rvalid);
      dat = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge sys_clk);
      s_axi_rready <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic wait_halt(input logic v, input int n);
      repeat (n) if (coreHalt !== v) @(posedge sys_clk);
      cmdWait <= 1'b0;
      cmdStop <= 1'b0;
   endtask
   // level requests removed once serviced, then the handler is let finish
   task automatic wait_take();
      seen = 1'b0;
      repeat (40) if (!seen)
      begin
         @(negedge sys_clk);
         seen = irqTake === 1'b1;
         vec = irqVector;
      end
      @(posedge sys_clk);
      timerOverflowFlag <= 1'b0;
      converterEocFlag <= 1'b0;
      source1Pin <= 1'b1;
      repeat (20) @(posedge sys_clk);
   endtask
   task automatic t_nmi();
      nmiPin <= 1'b0;
      seen = 1'b0;
      repeat (40) if (!seen)
      begin
         @(negedge sys_clk);
         seen = irqTake === 1'b1;
         vec = irqVector;
      end
      @(posedge sys_clk);
      cmdWait <= 1'b1;
      nmiPin <= 1'b1;
      check("nmi vector", IWPC_VEC_NMI, vec);
      check("nmi mode", 1'b1, nmiMode);
      wait_halt(1'b1, 30);
      timerOverflowFlag <= 1'b1;
      wait_halt(1'b0, 8);
      check("resume", 1'b1, resumeNext);
      check("still nmi", 1'b1, nmiMode);
      wait_take();
      check("after nmi", IWPC_VEC_TIMER, vec);
      check("int mode", 1'b0, intMode);
      axi_write(IWPC_OPT_ADDR, 32'h50, 4'h1);
      source1Pin <= 1'b0;
      wait_take();
      check("level vector", IWPC_VEC_PORTA, vec);
      axi_write(IWPC_OPT_ADDR, 32'h10, 4'h1);
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_regs();
      axi_read(12'h0CC);
      check("status", 32'h10, dat);
      axi_write(IWPC_OPT_ADDR, 32'h10, 4'h0);
      check("strobe resp", IWPC_RESP_SLVERR, rsp);
      axi_write(IWPC_OPT_ADDR, 32'h9F, 4'h1);
      check("write resp", IWPC_RESP_OKAY, rsp);
      axi_read(IWPC_OPT_ADDR);
      check("option read", 32'h0, dat);
      axi_read(12'h100);
      check("unmapped", IWPC_RESP_SLVERR, rsp);
   endtask
   task automatic t_route();
      for (int k = 0; k < 2; k++)
      begin
         timerOverflowFlag <= k == 0;
         timerIrqEnable <= 1'b1;
         converterEocFlag <= k == 1;
         converterIrqEnable <= 1'b1;
         wait_take();
         check("vector", k == 0 ? IWPC_VEC_TIMER : IWPC_VEC_ADC, vec);
      end
      converterEocFlag <= 1'b1;
      converterIrqEnable <= 1'b0;
      wait_take();
      check("gated take", 1'b0, seen);
      axi_write(IWPC_OPT_ADDR, 32'h8F, 4'h1);
      converterEocFlag <= 1'b1;
      converterIrqEnable <= 1'b1;
      wait_take();
      check("masked take", 1'b0, seen);
      axi_write(IWPC_OPT_ADDR, 32'h9F, 4'h1);
   endtask
   task automatic t_wait(input logic wd);
      watchdogActive <= wd;
      cmdWait <= !wd;
      cmdStop <= wd;
      wait_halt(1'b1, 30);
      repeat (10) @(posedge sys_clk);
      check("halted", 1'b1, coreHalt);
      check("osc runs", 1'b0, oscStop);
      timerOverflowFlag <= 1'b1;
      wait_halt(1'b0, 8);
      check("quick wake", 1'b0, coreHalt);
      wait_take();
      check("wake vector", IWPC_VEC_TIMER, vec);
      watchdogActive <= 1'b0;
   endtask
   task automatic t_stop();
      cmdStop <= 1'b1;
      wait_halt(1'b1, 30);
      check("osc stopped", 1'b1, oscStop);
      source2Pin <= 1'b0;
      repeat (100) @(posedge sys_clk);
      check("stabilising", 1'b1, coreHalt);
      wait_halt(1'b0, IWPC_STAB_CYC + 50);
      check("stop wake", 1'b0, coreHalt);
      wait_take();
      check("edge vector", IWPC_VEC_PORTB, vec);
      source2Pin <= 1'b1;
   endtask
   task automatic t_gen_off();
      axi_write(IWPC_OPT_ADDR, 32'h8F, 4'h1);
      nmiPin <= 1'b0;
      wait_take();
      check("nmi gen off", IWPC_VEC_NMI, vec);
      nmiPin <= 1'b1;
      cmdWait <= 1'b1;
      wait_halt(1'b1, 30);
      timerOverflowFlag <= 1'b1;
      repeat (40) @(posedge sys_clk);
      check("no wake", 1'b1, coreHalt);
      nmiPin <= 1'b0;
      repeat (20) @(posedge sys_clk);
      check("nmi no wake", 1'b1, coreHalt);
      reset_n <= 1'b0;
      timerOverflowFlag <= 1'b0;
      nmiPin <= 1'b1;
      repeat (4) @(posedge sys_clk);
      reset_n <= 1'b1;
      @(posedge sys_clk);
      check("reset exit", 1'b0, coreHalt);
      axi_read(12'h0CC);
      check("status", 32'h10, dat);
   endtask
   initial
   begin
      #200us;
      num_errors++;
      report_and_stop();
   end
   initial
   begin
      repeat (16) @(posedge sys_clk);
      reset_n <= 1'b1;
      @(posedge sys_clk);
      t_regs();
      t_route();
      t_wait(1'b0);
      t_wait(1'b1);
      t_stop();
      t_nmi();
      t_gen_off();
      report_and_stop();
   end
endmodule // iwpc_ctrl_test
